// ===== hw/tape_deck_mode_sequencer.v
// Function
// [R1] Power-up: hold STOP, ignore all inputs
// [R2] After hold: timer pin selects STOP/PLAY/REC
// [R3] Timer pin ignored after power-up hold
// [R4] Auto input idles high; short low pulse
// [R5] Auto: PLAY/REC to rewind, rewind to PLAY, fast_wind to STOP
// [R6] Tick runs only while sequencing a change; the code also runs it through the power-up hold
// [R7] Short delay two ticks, long sixteen
// [R8] Power-up hold lasts 68 ticks
// [R9] Mute release follows play by long delay
// [R10] Fixed output pattern per mode
// [R11] Wind/play swaps pass through STOP 0.4 s
// [R12] Play solenoid, then motor and brake, then unmute
// [R13] Two keys held: last released wins
// [R14] Tri-level keys decoded to key events once
`timescale 1ns/1ps
`include "deck_seq_defines.vh"

module tape_deck_mode_sequencer #(
  parameter [31:0] TICK_CYCLES = `TICK_CYCLES_DEF
)(
  // Clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  input wire ce_i,
  // Tri-level key and timer pins, as high and low comparator levels
  input wire pause_stop_hi_i,
  input wire pause_stop_lo_i,
  input wire fast_wind_play_hi_i,
  input wire fast_wind_play_lo_i,
  input wire rewind_rec_hi_i,
  input wire rewind_rec_lo_i,
  input wire timer_hi_i,
  input wire timer_lo_i,
  // Control pins
  input wire auto_n_i,
  input wire anti_rec_n_i,
  // Mechanism and amplifier
  output wire pause_n_o,
  output wire mute_o,
  output wire rec_n_o,
  output wire play_n_o,
  output wire reel_brake_release_out_o,
  output wire motor_fwd_n_o,
  output wire motor_rev_n_o,
  // AXI4-Lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  localparam [3:0] ST_HOLD = 4'h1;
  localparam [3:0] ST_IDLE = 4'h2;
  localparam [3:0] ST_GAP = 4'h4;
  localparam [3:0] ST_SEQ = 4'h8;

  function [6:0] pattern;
    input [2:0] m;
    begin
      case (m)
        `M_FWIND: pattern = `P_FWIND;
        `M_REWIND: pattern = `P_REWIND;
        `M_PLAY: pattern = `P_PLAY;
        `M_REC: pattern = `P_REC;
        `M_PAUSE: pattern = `P_PAUSE;
        `M_RECPAUSE: pattern = `P_RECPAUSE;
        default: pattern = `P_STOP;
      endcase
    end
  endfunction

  // Key request from current mode; bit 3 marks a valid change
  function [3:0] resolve;
    input [2:0] cur;
    input [2:0] req;
    input anti;
    reg [2:0] m;
    begin
      m = req;
      if (req == `M_PAUSE && cur == `M_REC)
        m = `M_RECPAUSE;
      if (req == `M_PLAY && cur == `M_RECPAUSE)
        m = `M_REC;
      if ((m == `M_REC || m == `M_RECPAUSE) && anti)
        resolve = 4'h0;
      else if (m == `M_PAUSE && (cur == `M_FWIND || cur == `M_REWIND))
        resolve = 4'h0;
      else if (m == cur)
        resolve = 4'h0;
      else
        resolve = {1'b1, m};
    end
  endfunction

  // Pin synchroniser: stable value moves once stages two and three agree
  reg [`PIN_W-1:0] sync1;
  reg [`PIN_W-1:0] sync2;
  reg [`PIN_W-1:0] sync3;
  reg [`PIN_W-1:0] pins;
  wire [`PIN_W-1:0] raw = {auto_n_i, anti_rec_n_i, timer_hi_i, timer_lo_i,
    pause_stop_hi_i, pause_stop_lo_i, fast_wind_play_hi_i, fast_wind_play_lo_i,
    rewind_rec_hi_i, rewind_rec_lo_i};

  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      sync1 <= `PIN_IDLE;
      sync2 <= `PIN_IDLE;
      sync3 <= `PIN_IDLE;
      pins <= `PIN_IDLE;
    end
    else if (ce_i)
    begin
      sync1 <= raw;
      sync2 <= sync1;
      sync3 <= sync2;
      pins <= (sync2 & ~(sync2 ^ sync3)) | (pins & (sync2 ^ sync3));
    end
  end

  wire k_pause = pins[5];
  wire k_stop = pins[4];
  wire k_fwind = pins[3];
  wire k_play = pins[2];
  wire k_rew = pins[1];
  wire k_rec = pins[0];
  wire anti_rec = ~pins[`PIN_ANTI_N];

  // Key decode; a floating pin is neither high nor low [R14]
  reg [3:0] key_code;
  always @*
  begin
    key_code = 4'h0;
    if (k_rec && k_play)
      key_code = {1'b1, `M_REC};
    else if (k_rec && k_pause)
      key_code = {1'b1, `M_RECPAUSE};
    else if ({k_pause, k_stop, k_fwind, k_play, k_rew, k_rec} == 6'h20)
      key_code = {1'b1, `M_PAUSE};
    else if ({k_pause, k_stop, k_fwind, k_play, k_rew, k_rec} == 6'h10)
      key_code = {1'b1, `M_STOP};
    else if ({k_pause, k_stop, k_fwind, k_play, k_rew, k_rec} == 6'h08)
      key_code = {1'b1, `M_FWIND};
    else if ({k_pause, k_stop, k_fwind, k_play, k_rew, k_rec} == 6'h04)
      key_code = {1'b1, `M_PLAY};
    else if ({k_pause, k_stop, k_fwind, k_play, k_rew, k_rec} == 6'h02)
      key_code = {1'b1, `M_REWIND};
  end

  reg [3:0] state;
  reg [2:0] mode;
  reg [6:0] out_pat;
  reg [31:0] presc;
  reg [6:0] tcnt;
  reg [3:0] key_prev;
  reg auto_prev;
  reg key_inhibit;
  reg pend_v;
  reg [2:0] pend_m;
  reg sw_req_v;
  reg [2:0] sw_req_m;

  // Tick exists only outside idle, like the gated RC oscillator [R6]
  wire tick = (state != ST_IDLE) && (presc == TICK_CYCLES - 32'd1);

  // One event per change of the held key set; dropping from two keys
  // to one selects the key still held, so the last one released wins [R13]
  wire key_ev = key_code[3] && (key_code != key_prev) && !key_inhibit; // [R14]
  wire auto_ev = auto_prev && !pins[`PIN_AUTO_N]; // [R4]
  reg [3:0] auto_req;
  always @*
  begin
    case (mode)
      `M_PLAY, `M_REC: auto_req = {1'b1, `M_REWIND}; // [R5]
      `M_REWIND: auto_req = {1'b1, `M_PLAY}; // [R5]
      `M_FWIND: auto_req = {1'b1, `M_STOP}; // [R5]
      default: auto_req = 4'h0;
    endcase
  end

  wire [3:0] key_res = resolve(mode, key_code[2:0], anti_rec);
  wire [3:0] sw_res = resolve(mode, sw_req_m, anti_rec);
  wire [3:0] req = (key_ev && key_res[3]) ? key_res :
    (auto_ev && auto_req[3]) ? auto_req : (sw_req_v ? sw_res : 4'h0);

  function needs_gap;
    input [2:0] cur;
    input [2:0] nxt;
    reg cur_wind;
    reg cur_play;
    reg nxt_wind;
    reg nxt_play;
    begin
      cur_wind = (cur == `M_FWIND) || (cur == `M_REWIND);
      cur_play = (cur == `M_PLAY) || (cur == `M_REC);
      nxt_wind = (nxt == `M_FWIND) || (nxt == `M_REWIND);
      nxt_play = (nxt == `M_PLAY) || (nxt == `M_REC);
      needs_gap = (cur_wind && (nxt_wind || nxt_play)) || (cur_play && nxt_wind);
    end
  endfunction

  wire timer_hi_sel = pins[7] && !pins[6];
  wire timer_lo_sel = pins[6] && !pins[7];
  wire [3:0] timer_req = timer_hi_sel ? {1'b1, `M_PLAY} :
    (timer_lo_sel ? {1'b1, `M_REC} : 4'h0);
  wire [3:0] launch = (state == ST_HOLD) ? timer_req : (pend_v ? {1'b1, pend_m} : req);
  wire hold_done = (state == ST_HOLD) && tick && (tcnt == `T3_TICKS - 7'd1); // [R8]
  wire seq_done = tick && (tcnt == `T1_TICKS + `T2_TICKS - 7'd1);
  wire can_launch = (state == ST_IDLE) || hold_done || (state == ST_SEQ && seq_done);

  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state <= ST_HOLD;
      mode <= `M_STOP;
      out_pat <= `P_STOP;
      presc <= 32'h0;
      tcnt <= 7'h0;
      key_prev <= 4'h0;
      auto_prev <= 1'b1;
      pend_v <= 1'b0;
      pend_m <= `M_STOP;
    end
    else if (ce_i)
    begin
      key_prev <= key_code;
      auto_prev <= pins[`PIN_AUTO_N];
      if (state == ST_IDLE || tick)
        presc <= 32'h0;
      else
        presc <= presc + 32'd1;
      if (tick)
        tcnt <= tcnt + 7'd1;
      if (state != ST_HOLD && !can_launch && req[3])
      begin
        pend_v <= 1'b1;
        pend_m <= req[2:0];
      end
      // Final pattern first, so a change launched at this edge overrides it
      if (state == ST_SEQ && seq_done)
        out_pat <= pattern(mode); // [R7] [R9] [R10] [R12]
      if (can_launch)
      begin
        // Hold ignores keys; only the timer pin is read, once, here [R1] [R2] [R3]
        if (state != ST_HOLD && pend_v)
          pend_v <= 1'b0;
        if (launch[3] && (state != ST_HOLD || launch[2:0] != `M_STOP))
        begin
          mode <= launch[2:0];
          tcnt <= 7'h0;
          if (needs_gap(mode, launch[2:0]))
          begin
            out_pat <= `P_STOP; // [R11]
            state <= ST_GAP;
          end
          else
          begin
            // Muting starts at once; releasing it waits for the mechanism
            out_pat <= out_pat | (pattern(launch[2:0]) & `MASK_MUTE);
            state <= ST_SEQ;
          end
        end
        else
          state <= ST_IDLE;
      end
      else if (state == ST_GAP && tick && tcnt == `GAP_TICKS - 7'd1)
      begin
        tcnt <= 7'h0; // [R11]
        state <= ST_SEQ;
      end
      else if (state == ST_SEQ && tick)
      begin
        if (tcnt == `T1_TICKS - 7'd1)
          out_pat <= (out_pat & ~`MASK_SOL) | (pattern(mode) & `MASK_SOL); // [R7] [R12]
        if (tcnt == `T1_TICKS + `T1_TICKS - 7'd1)
          out_pat <= (out_pat & ~`MASK_MOT) | (pattern(mode) & `MASK_MOT); // [R12]
      end
    end
  end

  assign {pause_n_o, mute_o, rec_n_o, play_n_o, reel_brake_release_out_o,
    motor_fwd_n_o, motor_rev_n_o} = out_pat; // [R10]

  // AXI4-Lite: address and data taken in either order, one write at a time
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire do_write = aw_held && w_held && !s_axi_bvalid;

  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0;
      key_inhibit <= 1'b0;
      sw_req_v <= 1'b0;
      sw_req_m <= `M_STOP;
    end
    else if (ce_i)
    begin
      sw_req_v <= 1'b0;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        if (aw_addr == `REG_CTRL && w_strb[0])
          key_inhibit <= w_data[`CTRL_KEY_INHIBIT];
        else if (aw_addr == `REG_REQUEST && w_strb[0])
        begin
          sw_req_v <= (state != ST_HOLD); // [R1]
          sw_req_m <= w_data[2:0];
        end
        else if (aw_addr != `REG_STATUS && aw_addr != `REG_CTRL && aw_addr != `REG_REQUEST)
          s_axi_bresp <= 2'h2;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        s_axi_rdata <= 32'h0;
        if (s_axi_araddr == `REG_STATUS)
          s_axi_rdata <= {26'h0, state == ST_HOLD, state != ST_IDLE, 1'b0, mode};
        else if (s_axi_araddr == `REG_CTRL)
          s_axi_rdata <= {31'h0, key_inhibit};
        else if (s_axi_araddr != `REG_REQUEST)
          s_axi_rresp <= 2'h2;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ===== inc/deck_seq_defines.vh
`ifndef DECK_SEQ_DEFINES_VH
`define DECK_SEQ_DEFINES_VH

// Timing
`define CLK_MHZ 200
`define TOSC_US 25000
`define TICK_CYCLES_DEF (`TOSC_US * `CLK_MHZ)
`define T1_TICKS 7'd2
`define T2_TICKS 7'd16
`define T3_TICKS 7'd68
`define GAP_TICKS 7'd16

// Mode codes
`define M_STOP 3'h0
`define M_FWIND 3'h1
`define M_REWIND 3'h2
`define M_PLAY 3'h3
`define M_REC 3'h4
`define M_PAUSE 3'h5
`define M_RECPAUSE 3'h6

// Output pattern {pause_n, mute, rec_n, play_n, brake_rel, motor_fwd_n, motor_rev_n}
`define P_STOP 7'h7b
`define P_FWIND 7'h7d
`define P_REWIND 7'h7e
`define P_PLAY 7'h55
`define P_REC 7'h45
`define P_RECPAUSE 7'h0b
`define P_PAUSE 7'h3b
`define MASK_SOL 7'h58
`define MASK_MOT 7'h07
`define MASK_MUTE 7'h20

// Register map
`define REG_STATUS 8'h00
`define REG_CTRL 8'h04
`define REG_REQUEST 8'h08
`define STAT_BUSY 4
`define STAT_HOLD 5
`define CTRL_KEY_INHIBIT 0

// Pin sync vector positions and idle levels
`define PIN_W 10
`define PIN_IDLE 10'h300
`define PIN_AUTO_N 9
`define PIN_ANTI_N 8

`endif

// ===== test/deck_keys_model.sv
`timescale 1ns/1ps
module deck_keys_model #(
  parameter [7:0] AUTO_LEN = 8'd40
)(
  // Bench commands
  input wire clk_i,
  input wire [5:0] keys_i,
  input wire [1:0] timer_sel_i,
  input wire auto_req_i,
  // Pins towards the sequencer
  output wire [7:0] pins_o,
  output wire auto_n_o
);
  reg [7:0] auto_cnt = 8'h00;
  // One pin carries two keys, so its pair is never both high
  assign pins_o = {timer_sel_i == 2'h1, timer_sel_i == 2'h2,
    keys_i[3] & ~keys_i[5], keys_i[5] & ~keys_i[3],
    keys_i[2] & ~keys_i[1], keys_i[1] & ~keys_i[2],
    keys_i[4] & ~keys_i[0], keys_i[0] & ~keys_i[4]};
  // Idles high; pulse is five ticks, well short of sixteen
  assign auto_n_o = auto_cnt == 8'h00;
  always @(posedge clk_i)
  begin
    if (auto_req_i && auto_cnt == 8'h00)
      auto_cnt <= AUTO_LEN;
    else if (auto_cnt != 8'h00)
      auto_cnt <= auto_cnt - 8'h01;
  end
endmodule

// ===== test/deck_seq_props.sv
`timescale 1ns/1ps
`include "deck_seq_defines.vh"
module deck_seq_props #(
  parameter [31:0] TICK_CYCLES = `TICK_CYCLES_DEF
)(
  // Clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  // Deck outputs and read channel
  input wire pause_n_o,
  input wire mute_o,
  input wire rec_n_o,
  input wire play_n_o,
  input wire reel_brake_release_out_o,
  input wire motor_fwd_n_o,
  input wire motor_rev_n_o,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata
);
  wire [6:0] outs = {pause_n_o, mute_o, rec_n_o, play_n_o, reel_brake_release_out_o,
    motor_fwd_n_o, motor_rev_n_o};
  reg [31:0] up, since_play, since_fwd;
  reg prev_play, prev_fwd;
  // Saturating ages, so long idle spans never wrap
  always @(posedge clk_i)
  begin
    prev_play <= play_n_o;
    prev_fwd <= motor_fwd_n_o;
    up <= sys_rst_i ? 32'h0 : up + {31'h0, ~&up};
    since_play <= (prev_play & ~play_n_o) ? 32'h1 : since_play + {31'h0, ~&since_play};
    if (sys_rst_i | (~prev_fwd & motor_fwd_n_o))
      since_fwd <= 32'h1;
    else
      since_fwd <= since_fwd + {31'h0, ~&since_fwd};
  end
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  a_hold_stop: assert property (up < 68 * TICK_CYCLES |-> outs == `P_STOP)
    else $error("stop pattern lost in hold");
  a_motor_lag: assert property ($fell(motor_fwd_n_o) && !play_n_o
    |-> since_play == 2 * TICK_CYCLES) else $error("motor lag wrong");
  a_mute_lag: assert property ($fell(mute_o) && !play_n_o
    |-> since_play == 16 * TICK_CYCLES) else $error("mute lag wrong");
  a_brake_motor: assert property ($rose(reel_brake_release_out_o)
    |-> !(motor_fwd_n_o & motor_rev_n_o)) else $error("brake freed without motor");
  a_motor_excl: assert property (motor_fwd_n_o | motor_rev_n_o)
    else $error("both motors on");
  a_rec_solenoid: assert property (!rec_n_o |-> !(play_n_o & pause_n_o))
    else $error("record alone");
  a_swap_gap: assert property ($fell(motor_rev_n_o) |-> since_fwd > 4 * TICK_CYCLES)
    else $error("reverse right after forward");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_read_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
endmodule

// ===== test/testbench.sv
`timescale 1ns/1ps
`include "deck_seq_defines.vh"
module testbench;
  localparam [31:0] TICK_CYCLES = 32'h8;
  localparam [48:0] PATS = {`P_RECPAUSE, `P_PAUSE, `P_REC, `P_PLAY, `P_REWIND, `P_FWIND, `P_STOP};
  localparam [11:0] KEY_MODE = {`M_REWIND, `M_FWIND, `M_PLAY, `M_STOP};
  reg clk_i = 1'b0;
  reg sys_rst_i = 1'b1;
  reg ce_i = 1'b1;
  reg anti_rec_n_i = 1'b1;
  reg auto_req = 1'b0;
  reg [5:0] keys = 6'h00;
  reg [1:0] timer_sel = 2'h1;
  reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'hf;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire pause_stop_hi_i, pause_stop_lo_i, fast_wind_play_hi_i, fast_wind_play_lo_i;
  wire rewind_rec_hi_i, rewind_rec_lo_i, timer_hi_i, timer_lo_i, auto_n_i;
  wire pause_n_o, mute_o, rec_n_o, play_n_o, reel_brake_release_out_o, motor_fwd_n_o;
  wire motor_rev_n_o, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [6:0] outs = {pause_n_o, mute_o, rec_n_o, play_n_o, reel_brake_release_out_o,
    motor_fwd_n_o, motor_rev_n_o};
  integer err_total = 0, compares = 0, i;
  reg [31:0] d, seed;
  reg [1:0] r;
  reg [2:0] k;
  always #2.5 clk_i = ~clk_i;
  tape_deck_mode_sequencer #(.TICK_CYCLES(TICK_CYCLES)) dut (.*);
  deck_keys_model partner (.clk_i, .keys_i(keys), .timer_sel_i(timer_sel), .auto_req_i(auto_req),
    .pins_o({timer_hi_i, timer_lo_i, rewind_rec_hi_i, rewind_rec_lo_i, fast_wind_play_hi_i,
    fast_wind_play_lo_i, pause_stop_hi_i, pause_stop_lo_i}), .auto_n_o(auto_n_i));
  task check(input string what, input [31:0] seen, input [31:0] exp);
    compares = compares + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task conclude;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task axw(input [7:0] a, input [31:0] v, output [1:0] resp);
    reg ta, tw;
    @(posedge clk_i);
    ta = 1'b0;
    tw = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ta && tw))
    begin
      @(negedge clk_i);
      ta = ta | s_axi_awready;
      tw = tw | s_axi_wready;
      @(posedge clk_i);
      s_axi_awvalid <= !ta;
      s_axi_wvalid <= !tw;
    end
    do @(negedge clk_i); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    @(posedge clk_i);
    s_axi_bready <= 1'b0;
  endtask
  task axr(input [7:0] a, output [31:0] v, output [1:0] resp);
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge clk_i); while (!s_axi_arready);
    @(posedge clk_i);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk_i); while (!s_axi_rvalid);
    v = s_axi_rdata;
    resp = s_axi_rresp;
    @(posedge clk_i);
    s_axi_rready <= 1'b0;
  endtask
  function [6:0] exp_pat(input [2:0] m);
    exp_pat = PATS[m * 7 +: 7];
  endfunction
  // Fresh power-up with the timer pin at a chosen level
  task restart(input [1:0] sel);
    @(posedge clk_i);
    timer_sel <= sel;
    sys_rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
  endtask
  // All ones stands for an auto pulse instead of a key
  task step(input [5:0] key, input [2:0] want);
    integer n;
    @(posedge clk_i);
    keys <= (key == 6'h3f) ? 6'h00 : key;
    auto_req <= key == 6'h3f;
    repeat (3 * TICK_CYCLES) @(posedge clk_i);
    keys <= 6'h00;
    auto_req <= 1'b0;
    d = 32'h30;
    for (n = 0; n < 400 && d[5:4] != 2'h0; n = n + 1)
      axr(`REG_STATUS, d, r);
    check("idle", {30'h0, d[5:4]}, 32'h0);
    check("mode", {29'h0, d[2:0]}, {29'h0, want});
    check("outputs", {25'h0, outs}, {25'h0, exp_pat(want)});
  endtask
  initial
  begin
    seed = $urandom(32'h2937);
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    axr(`REG_CTRL, d, r);
    check("ctrl reset", d, 32'h0);
    step(6'h04, `M_PLAY);
    timer_sel <= 2'h2;
    step(6'h00, `M_PLAY);
    step(6'h01, `M_STOP);
    step(6'h04, `M_FWIND);
    step(6'h08, `M_REWIND);
    step(6'h3f, `M_PLAY);
    step(6'h3f, `M_REWIND);
    step(6'h04, `M_FWIND);
    step(6'h3f, `M_STOP);
    step(6'h3f, `M_STOP);
    keys <= 6'h0c;
    repeat (3 * TICK_CYCLES) @(posedge clk_i);
    step(6'h08, `M_REWIND);
    anti_rec_n_i <= 1'b0;
    step(6'h22, `M_REWIND);
    anti_rec_n_i <= 1'b1;
    step(6'h22, `M_REC);
    step(6'h3f, `M_REWIND);
    step(6'h10, `M_REWIND);
    $display("key and auto test done");
    axw(`REG_CTRL, 32'h1, r);
    check("ctrl write", {30'h0, r}, 32'h0);
    axr(`REG_CTRL, d, r);
    check("ctrl", d, 32'h1);
    step(6'h02, `M_REWIND);
    axw(`REG_CTRL, 32'h0, r);
    axw(`REG_REQUEST, {29'h0, `M_PLAY}, r);
    step(6'h00, `M_PLAY);
    axw(8'h1c, 32'h0, r);
    check("bad write", {30'h0, r}, 32'h2);
    axr(8'h1c, d, r);
    check("bad read", {30'h0, r}, 32'h2);
    $display("register test done");
    // Keys pressed and released while frozen must leave no trace
    ce_i <= 1'b0;
    keys <= 6'h01;
    repeat (3 * TICK_CYCLES) @(posedge clk_i);
    keys <= 6'h00;
    repeat (4) @(posedge clk_i);
    ce_i <= 1'b1;
    step(6'h00, `M_PLAY);
    restart(2'h0);
    step(6'h00, `M_STOP);
    restart(2'h2);
    step(6'h00, `M_REC);
    $display("enable and power-up test done");
    for (i = 0; i < 12; i = i + 1)
    begin
      k = 3'($urandom % 4);
      step(6'h01 << k, KEY_MODE[k * 3 +: 3]);
    end
    $display("random test done");
    conclude;
  end
  initial
  begin
    #300000;
    err_total = err_total + 1;
    conclude;
  end
endmodule
bind tape_deck_mode_sequencer deck_seq_props #(.TICK_CYCLES(TICK_CYCLES)) props (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .pause_n_o(pause_n_o), .mute_o(mute_o),
  .rec_n_o(rec_n_o), .play_n_o(play_n_o), .reel_brake_release_out_o(reel_brake_release_out_o),
  .motor_fwd_n_o(motor_fwd_n_o), .motor_rev_n_o(motor_rev_n_o), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));
